// file: shared/fetbe_pkg.sv
/*
  shared types and constants of the flag, extend, trap and branch
  execution unit. assumes a 20-bit address space and 16-bit words.
*/
`default_nettype none
package fetbe_pkg;
  // operation codes handed in by the decoder
  typedef enum logic [2:0] {
    OP_NOP = 3'b000, OP_SEXT = 3'b001, OP_FLAG_CLR = 3'b010, OP_FLAG_SET = 3'b011,
    OP_INC = 3'b100, OP_INT  = 3'b101, OP_OVERFLOW_TRAP_INSTR = 3'b110, OP_JMP_COND = 3'b111
  } fetbe_op_t;
  // destination operand kinds
  typedef enum logic [2:0] {
    DK_ACC_LB = 3'b000, DK_ACC_HB = 3'b001, DK_SBASE8 = 3'b010,
    DK_FBASE8 = 3'b011, DK_ABS16  = 3'b100, DK_ADR0   = 3'b101,
    DK_ADR1   = 3'b110, DK_OTHER  = 3'b111
  } fetbe_kind_t;
  // branch conditions
  typedef enum logic [3:0] {
    CND_HIGHER_SAME = 4'h0, CND_LOWER    = 4'h1, CND_EQUAL     = 4'h2,
    CND_NOT_EQUAL   = 4'h3, CND_HIGHER   = 4'h4, CND_LOWER_SAME = 4'h5,
    CND_POSITIVE    = 4'h6, CND_NEGATIVE = 4'h7, CND_SIGNED_GE = 4'h8,
    CND_SIGNED_LE   = 4'h9, CND_SIGNED_GT = 4'hA, CND_SIGNED_LT = 4'hB,
    CND_OVF         = 4'hC, CND_NO_OVF   = 4'hD
  } fetbe_cond_t;
  // trap sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PUSH_HI = 3'b001, ST_PUSH_LO = 3'b010,
    ST_FETCH = 3'b011, ST_WAIT_VEC = 3'b100
  } fetbe_state_t;
  // flag register bit positions
  localparam int FL_CARRY = 0;
  localparam int FL_DBG   = 1;
  localparam int FL_ZERO  = 2;
  localparam int FL_SIGN  = 3;
  localparam int FL_BANK  = 4;
  localparam int FL_OVF   = 5;
  localparam int FL_IEN   = 6;
  localparam int FL_STK   = 7;
  localparam logic [7:0]  FLAG_RST      = 8'h00;
  localparam logic [19:0] OVERFLOW_TRAP_INSTR_VEC_ADDR = 20'hFFFE0;
  localparam logic [19:0] INT_LEN       = 20'h00002;
  localparam logic [19:0] OVERFLOW_TRAP_INSTR_LEN      = 20'h00001;
  localparam logic [19:0] SP_STEP       = 20'h00002;
  localparam logic [5:0]  INT_SYS_MAX   = 6'h1F;
  localparam logic [19:0] BR_BASE_SHORT = 20'h00001;
  localparam logic [19:0] BR_BASE_LONG  = 20'h00002;
  // one instruction request
  typedef struct packed {
    fetbe_op_t   op;
    logic        wide;
    fetbe_kind_t kind;
    logic [2:0]  flagSel;
    logic [5:0]  intNum;
    fetbe_cond_t cond;
    logic [7:0]  disp;
    logic [15:0] operand;
    logic [19:0] pc;
  } fetbe_req_t;
endpackage
`default_nettype wire

// file: src/fetbe_exec.sv
/*
  execution unit for sign extend, flag clear/set, increment, software
  and overflow traps and conditional jumps. assumes the decoder holds
  a request until accepted and answers vector reads with vecAck.
*/
// Operation
// RQ1: byte sign extend copies bit 7 overflow_trap_instr upper byte, 16-bit result.
// RQ2: word sign extend writes sign of low accumulator overflow_trap_instr high word.
// RQ3: byte extend sets sign and zero from result; word keeps them.
// RQ4: flag clear writes 0 to one selected flag only.
// RQ5: flag set writes 1 to one selected flag only.
// RQ6: increment adds one, writes back, updates sign and zero.
// RQ7: byte increment only on accumulator bytes, base displacements, abs16.
// RQ8: trap pushes high part with flags, then low part; vector fetch.
// RQ9: number 31 or less clears stack-select and uses interrupt stack.
// RQ10: number 32 or more stacks through pointer selected by flag.
// RQ11: software interrupts are taken regardless of interrupt enable.
// RQ12: flags saved before change; enable and debug flags cleared.
// RQ13: software interrupt number limited to 0 through 63.
// RQ14: overflow trap only when overflow set, via fixed vector.
// RQ15: overflow trap unmaskable; clears stack-select, enable, debug.
// RQ16: conditional jump loads target when true, never touches flags.
// RQ17: unsigned and equality conditions from carry and zero.
// RQ18: signed and flag conditions from sign, overflow and zero.
// RQ19: target spans -127..+128 or -126..+129 from instruction start.
// RQ20: word increment wraps at 16 bits, sign and zero updated.
`timescale 1ns/1ps
`default_nettype none
module fetbe_exec
  import fetbe_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // request
  input  wire logic         start,
  input  wire fetbe_req_t   reqIn,
  output logic              busy,
  output logic              done,
  output logic              illegalOp,
  // operand write back
  output logic              resultValid,
  output logic [15:0]       resultData,
  output logic              resultHighWr,
  output logic [15:0]       resultHigh,
  // stack pointers and table base
  input  wire logic [19:0]  intStackPtr,
  input  wire logic [19:0]  userStackPtr,
  input  wire logic [19:0]  intTableBase,
  output logic              spWr,
  output logic              spWrUser,
  output logic [19:0]       spOut,
  // stack writes and vector reads
  output logic              memWr,
  output logic [19:0]       memAddr,
  output logic [15:0]       memData,
  output logic              vecRd,
  output logic [19:0]       vecAddr,
  input  wire logic         vecAck,
  input  wire logic [19:0]  vecData,
  // program counter and flags
  output logic              pcWr,
  output logic [19:0]       pcOut,
  output logic [7:0]        flagReg
);
  if (ADDR_W != 20) begin : g_addr_check
    $error("fetbe_exec serves 20-bit addresses only");
  end

  fetbe_state_t state_reg;
  logic         accept;
  logic         trapGo;
  logic         incLegal;
  logic [19:0]  spBase_reg;
  logic         stackUser_reg;
  logic         sysInt_reg;
  logic [19:0]  retPc_reg;
  logic [19:0]  vecAddr_reg;
  logic [7:0]   savedFlags_reg;
  logic [15:0]  incSum;
  logic [15:0]  extByte;
  logic [19:0]  brTarget;

  // condition evaluation against the flag register
  function automatic logic condTrue(fetbe_cond_t c, logic [7:0] f);
    logic sx;
    sx = f[FL_SIGN] ^ f[FL_OVF];
    case (c)
      CND_HIGHER_SAME: condTrue = f[FL_CARRY];                   // [RQ17]
      CND_LOWER:       condTrue = !f[FL_CARRY];                  // [RQ17]
      CND_EQUAL:       condTrue = f[FL_ZERO];                    // [RQ17]
      CND_NOT_EQUAL:   condTrue = !f[FL_ZERO];                   // [RQ17]
      CND_HIGHER:      condTrue = f[FL_CARRY] & !f[FL_ZERO];     // [RQ17]
      CND_LOWER_SAME:  condTrue = !(f[FL_CARRY] & !f[FL_ZERO]);  // [RQ17]
      CND_POSITIVE:    condTrue = !f[FL_SIGN];                   // [RQ18]
      CND_NEGATIVE:    condTrue = f[FL_SIGN];                    // [RQ18]
      CND_SIGNED_GE:   condTrue = !sx;                           // [RQ18]
      CND_SIGNED_LT:   condTrue = sx;                            // [RQ18]
      CND_SIGNED_GT:   condTrue = !(sx | f[FL_ZERO]);            // [RQ18]
      CND_SIGNED_LE:   condTrue = sx | f[FL_ZERO];               // [RQ18]
      CND_OVF:         condTrue = f[FL_OVF];                     // [RQ18]
      CND_NO_OVF:      condTrue = !f[FL_OVF];                    // [RQ18]
      default:         condTrue = 1'b0;
    endcase
  endfunction

  // signed-compare and overflow conditions use a two-byte opcode
  function automatic logic longCond(fetbe_cond_t c);
    longCond = (c >= CND_SIGNED_GE);
  endfunction

  // request acceptance and operand arithmetic
  assign busy     = (state_reg != ST_IDLE);
  assign accept   = start && !busy;
  assign trapGo   = (reqIn.op == OP_INT) ||                      // [RQ11]
                    (reqIn.op == OP_OVERFLOW_TRAP_INSTR && flagReg[FL_OVF]);    // [RQ14]
  assign incLegal = reqIn.wide ?                                 // [RQ7]
                    (reqIn.kind == DK_ADR0 || reqIn.kind == DK_ADR1) :
                    (reqIn.kind <= DK_ABS16);
  assign incSum   = reqIn.operand + 16'h0001;                    // [RQ20]
  assign extByte  = {{8{reqIn.operand[7]}}, reqIn.operand[7:0]}; // [RQ1]
  // displacement counted from the byte after the opcode
  assign brTarget = 20'(reqIn.pc + {{12{reqIn.disp[7]}}, reqIn.disp}
                    + (longCond(reqIn.cond) ? BR_BASE_LONG : BR_BASE_SHORT)); // [RQ19]

  // trap sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:     if (accept && trapGo) state_reg <= ST_PUSH_HI;
        ST_PUSH_HI:  state_reg <= ST_PUSH_LO;                    // [RQ8]
        ST_PUSH_LO:  state_reg <= ST_FETCH;
        ST_FETCH:    state_reg <= ST_WAIT_VEC;
        ST_WAIT_VEC: if (vecAck) state_reg <= ST_IDLE;
        default:     state_reg <= ST_IDLE;
      endcase
    end
  end

  // trap context captured at acceptance
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      spBase_reg     <= 20'h00000;
      stackUser_reg  <= 1'b0;
      sysInt_reg     <= 1'b0;
      retPc_reg      <= 20'h00000;
      vecAddr_reg    <= 20'h00000;
      savedFlags_reg <= FLAG_RST;
    end else if (accept && trapGo) begin
      savedFlags_reg <= flagReg;                                 // [RQ12]
      if (reqIn.op == OP_INT) begin
        // 6-bit number field caps the range at 63
        sysInt_reg    <= (reqIn.intNum <= INT_SYS_MAX);          // [RQ13]
        stackUser_reg <= (reqIn.intNum > INT_SYS_MAX) && flagReg[FL_STK]; // [RQ10]
        spBase_reg    <= (reqIn.intNum <= INT_SYS_MAX || !flagReg[FL_STK]) ?
                         intStackPtr : userStackPtr;             // [RQ9]
        retPc_reg     <= 20'(reqIn.pc + INT_LEN);
        vecAddr_reg   <= 20'(intTableBase + {12'h000, reqIn.intNum, 2'b00}); // [RQ8]
      end else begin
        sysInt_reg    <= 1'b1;                                   // [RQ15]
        stackUser_reg <= flagReg[FL_STK];
        spBase_reg    <= flagReg[FL_STK] ? userStackPtr : intStackPtr;
        retPc_reg     <= 20'(reqIn.pc + OVERFLOW_TRAP_INSTR_LEN);
        vecAddr_reg   <= OVERFLOW_TRAP_INSTR_VEC_ADDR;                          // [RQ14]
      end
    end
  end

  // stack pushes: high part with flags first, then low word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      memWr   <= 1'b0;
      memAddr <= 20'h00000;
      memData <= 16'h0000;
    end else begin
      memWr <= 1'b0;
      if (state_reg == ST_IDLE && accept && trapGo) begin
        memWr   <= 1'b1;
        memAddr <= 20'((reqIn.op == OP_INT &&
                       (reqIn.intNum <= INT_SYS_MAX || !flagReg[FL_STK])) ||
                       (reqIn.op == OP_OVERFLOW_TRAP_INSTR && !flagReg[FL_STK]) ?
                       intStackPtr - SP_STEP : userStackPtr - SP_STEP); // [RQ8]
        memData <= {4'h0, (reqIn.op == OP_INT) ? 4'(20'(reqIn.pc + INT_LEN) >> 16) :
                    4'(20'(reqIn.pc + OVERFLOW_TRAP_INSTR_LEN) >> 16), flagReg}; // [RQ12]
      end else if (state_reg == ST_PUSH_HI) begin
        memWr   <= 1'b1;
        memAddr <= 20'(spBase_reg - SP_STEP - SP_STEP);          // [RQ8]
        memData <= retPc_reg[15:0];
      end
    end
  end

  // stack pointer update and vector read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      spWr     <= 1'b0;
      spWrUser <= 1'b0;
      spOut    <= 20'h00000;
      vecRd    <= 1'b0;
      vecAddr  <= 20'h00000;
    end else begin
      spWr  <= 1'b0;
      vecRd <= 1'b0;
      if (state_reg == ST_PUSH_LO) begin
        spWr     <= 1'b1;
        spWrUser <= stackUser_reg;
        spOut    <= 20'(spBase_reg - SP_STEP - SP_STEP);
        vecRd    <= 1'b1;
        vecAddr  <= vecAddr_reg;
      end
    end
  end

  // flag register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagReg <= FLAG_RST;
    end else if (state_reg == ST_FETCH) begin
      flagReg[FL_IEN] <= 1'b0;                                   // [RQ12]
      flagReg[FL_DBG] <= 1'b0;                                   // [RQ15]
      if (sysInt_reg) flagReg[FL_STK] <= 1'b0;                   // [RQ9]
    end else if (accept) begin
      case (reqIn.op)
        OP_FLAG_CLR: flagReg[reqIn.flagSel] <= 1'b0;             // [RQ4]
        OP_FLAG_SET: flagReg[reqIn.flagSel] <= 1'b1;             // [RQ5]
        OP_SEXT: if (!reqIn.wide) begin                          // [RQ3]
          flagReg[FL_SIGN] <= extByte[15];
          flagReg[FL_ZERO] <= (extByte == 16'h0000);
        end
        OP_INC: if (incLegal) begin                              // [RQ6]
          flagReg[FL_SIGN] <= reqIn.wide ? incSum[15] : incSum[7];
          flagReg[FL_ZERO] <= reqIn.wide ? (incSum == 16'h0000) :
                              (incSum[7:0] == 8'h00);
        end
        default: ;
      endcase
    end
  end

  // operand results
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultValid  <= 1'b0;
      resultData   <= 16'h0000;
      resultHighWr <= 1'b0;
      resultHigh   <= 16'h0000;
      illegalOp    <= 1'b0;
    end else begin
      resultValid  <= 1'b0;
      resultHighWr <= 1'b0;
      illegalOp    <= 1'b0;
      if (accept && reqIn.op == OP_SEXT) begin
        resultValid <= 1'b1;
        if (reqIn.wide) begin
          resultData   <= reqIn.operand;
          resultHighWr <= 1'b1;
          resultHigh   <= {16{reqIn.operand[15]}};               // [RQ2]
        end else begin
          resultData <= extByte;                                 // [RQ1]
        end
      end else if (accept && reqIn.op == OP_INC) begin
        resultValid <= incLegal;
        illegalOp   <= !incLegal;                                // [RQ7]
        resultData  <= reqIn.wide ? incSum :                     // [RQ6]
                       {reqIn.operand[15:8], incSum[7:0]};
      end
    end
  end

  // program counter loads and completion
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcWr  <= 1'b0;
      pcOut <= 20'h00000;
      done  <= 1'b0;
    end else begin
      pcWr <= 1'b0;
      done <= 1'b0;
      if (state_reg == ST_WAIT_VEC && vecAck) begin
        pcWr  <= 1'b1;
        pcOut <= vecData;
        done  <= 1'b1;
      end else if (accept && !trapGo) begin
        done <= 1'b1;
        if (reqIn.op == OP_JMP_COND && condTrue(reqIn.cond, flagReg)) begin
          pcWr  <= 1'b1;                                         // [RQ16]
          pcOut <= brTarget;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_sext_byte_val: assert property (accept && reqIn.op == OP_SEXT && !reqIn.wide // [RQ1]
    |=> resultValid && resultData == {{8{$past(reqIn.operand[7])}}, $past(reqIn.operand[7:0])})
    else $error("byte sign extend wrong");
  a_sext_word_high: assert property (accept && reqIn.op == OP_SEXT && reqIn.wide // [RQ2]
    |=> resultHighWr && resultHigh == {16{$past(reqIn.operand[15])}})
    else $error("word sign extend high wrong");
  a_sext_word_flags: assert property (accept && reqIn.op == OP_SEXT && reqIn.wide // [RQ3]
    |=> $stable(flagReg)) else $error("word extend touched flags");
  a_flag_clear_one: assert property (accept && reqIn.op == OP_FLAG_CLR // [RQ4]
    |=> flagReg == ($past(flagReg) & ~(8'h01 << $past(reqIn.flagSel))))
    else $error("flag clear wrong");
  a_flag_set_one: assert property (accept && reqIn.op == OP_FLAG_SET // [RQ5]
    |=> flagReg == ($past(flagReg) | (8'h01 << $past(reqIn.flagSel))))
    else $error("flag set wrong");
  a_inc_zero_flag: assert property (accept && reqIn.op == OP_INC && incLegal // [RQ6]
    |=> flagReg[FL_ZERO] == ($past(reqIn.wide) ? resultData == 16'h0000 :
        resultData[7:0] == 8'h00)) else $error("increment zero flag wrong");
  a_inc_illegal: assert property (accept && reqIn.op == OP_INC && !incLegal // [RQ7]
    |=> illegalOp && !resultValid && $stable(flagReg)) else $error("bad increment taken");
  a_trap_push_seq: assert property (state_reg == ST_PUSH_HI |-> memWr // [RQ8]
    ##1 memWr ##1 (!memWr && spWr && vecRd) ##1 state_reg == ST_WAIT_VEC)
    else $error("trap push order wrong");
  a_sys_int_stack: assert property (accept && reqIn.op == OP_INT // [RQ9]
    && reqIn.intNum <= INT_SYS_MAX |=> ##2 spWr && !spWrUser ##2 !flagReg[FL_STK])
    else $error("system interrupt stack wrong");
  a_trap_flags_clr: assert property (state_reg == ST_FETCH // [RQ15]
    |=> !flagReg[FL_IEN] && !flagReg[FL_DBG]) else $error("trap flags not cleared");
  a_overflow_trap_instr_no_ovf: assert property (accept && reqIn.op == OP_OVERFLOW_TRAP_INSTR && !flagReg[FL_OVF] // [RQ14]
    |=> done && !busy && !memWr) else $error("overflow trap taken wrongly");
  a_jump_flags: assert property (accept && reqIn.op == OP_JMP_COND // [RQ16]
    |=> $stable(flagReg) && pcWr == condTrue($past(reqIn.cond), $past(flagReg)))
    else $error("jump decision wrong");

  c_int_taken: cover property (accept && reqIn.op == OP_INT ##[1:20] pcWr);
  c_overflow_trap_instr_taken: cover property (accept && reqIn.op == OP_OVERFLOW_TRAP_INSTR && flagReg[FL_OVF]);
  c_jump_taken: cover property (accept && reqIn.op == OP_JMP_COND ##1 pcWr);
endmodule
`default_nettype wire

// file: tb/flag_ext_trap_branch_exec_tb_top.sv
/*
  random and corner stimulus for the execution unit, with a flag model.
  assumes fetbe_pkg and fetbe_exec compiled first; vector reads answered here.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_ext_trap_branch_exec_tb_top;
  import fetbe_pkg::*;
  logic        ref_clk, arst_n, start, vecAck, busy, done, illegalOp;
  logic        resultValid, resultHighWr, spWr, spWrUser, memWr, vecRd, pcWr;
  fetbe_req_t  reqIn;
  logic [19:0] intStackPtr, userStackPtr, intTableBase, vecData, spOut, memAddr, vecAddr, pcOut;
  logic [15:0] resultData, resultHigh, memData, v, e;
  logic [7:0]  flagReg, expFlags, d;
  logic [19:0] p;
  int          miscompares, compares, i, k, w;
  integer      seed;

  fetbe_exec DUT (.ref_clk(ref_clk), .arst_n(arst_n), .start(start), .reqIn(reqIn),
    .busy(busy), .done(done), .illegalOp(illegalOp), .resultValid(resultValid),
    .resultData(resultData), .resultHighWr(resultHighWr), .resultHigh(resultHigh),
    .intStackPtr(intStackPtr), .userStackPtr(userStackPtr), .intTableBase(intTableBase),
    .spWr(spWr), .spWrUser(spWrUser), .spOut(spOut), .memWr(memWr), .memAddr(memAddr),
    .memData(memData), .vecRd(vecRd), .vecAddr(vecAddr), .vecAck(vecAck), .vecData(vecData),
    .pcWr(pcWr), .pcOut(pcOut), .flagReg(flagReg));

  // clock at 100 ns
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [19:0] g, input logic [19:0] x);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic fetbe_req_t mk(fetbe_op_t o, logic wd, fetbe_kind_t kd, logic [2:0] fs,
                                    logic [5:0] n, fetbe_cond_t c, logic [7:0] ds,
                                    logic [15:0] opd, logic [19:0] pc);
    mk = {o, wd, kd, fs, n, c, ds, opd, pc};
  endfunction

  // expected truth of a branch condition
  function automatic logic condTrue(logic [3:0] c, logic [7:0] f);
    logic cy, z, s, o;
    cy = f[FL_CARRY]; z = f[FL_ZERO]; s = f[FL_SIGN]; o = f[FL_OVF];
    case (c)
      4'h0: condTrue = cy;           4'h1: condTrue = !cy;
      4'h2: condTrue = z;            4'h3: condTrue = !z;
      4'h4: condTrue = cy & !z;      4'h5: condTrue = !(cy & !z);
      4'h6: condTrue = !s;           4'h7: condTrue = s;
      4'h8: condTrue = !(s ^ o);     4'h9: condTrue = (s ^ o) | z;
      4'hA: condTrue = !((s ^ o) | z); 4'hB: condTrue = s ^ o;
      4'hC: condTrue = o;            default: condTrue = !o;
    endcase
  endfunction

  // one request, checked while its one-cycle answer stands
  task automatic issue(input fetbe_req_t r, input logic chkDone);
    @(posedge ref_clk) #5 start = 1'b1;
    reqIn = r;
    @(posedge ref_clk) #1;
    if (chkDone) chk(20'(done), 20'h1);
    #4 start = 1'b0;
  endtask

  // load all flags through set and clear
  task automatic setFlags(input logic [7:0] f);
    for (int b = 0; b < 8; b++) begin
      issue(mk(f[b] ? OP_FLAG_SET : OP_FLAG_CLR, 1'b0, DK_OTHER, 3'(b), 6'h0, CND_OVF,
               8'h0, 16'h0, 20'h0), 1'b1);
      expFlags[b] = f[b];
    end
    chk(20'(flagReg), 20'(expFlags));
  endtask

  // software or overflow trap with stacking and vector fetch
  task automatic trap(input logic isInto, input logic [5:0] n);
    logic [19:0] sp, ret, pc, nv;
    logic        sys;
    intStackPtr  = 20'($random(seed)) & 20'hFFFFE;
    userStackPtr = 20'($random(seed)) & 20'hFFFFE;
    intTableBase = 20'($random(seed)) & 20'hFFFFC;
    pc  = 20'($random(seed));
    nv  = 20'($random(seed));
    sys = !isInto && n <= 6'd31;
    sp  = (sys || !expFlags[FL_STK]) ? intStackPtr : userStackPtr;
    ret = pc + (isInto ? 20'h1 : 20'h2);
    issue(mk(isInto ? OP_OVERFLOW_TRAP_INSTR : OP_INT, 1'b0, DK_OTHER, 3'h0, n, CND_OVF, 8'h0, 16'h0, pc), 1'b0);
    chk(20'(memWr), 20'h1);
    chk(memAddr, sp - 20'h2);
    chk(20'(memData), {8'h0, ret[19:16], expFlags});
    @(posedge ref_clk) #1;
    chk(memAddr, sp - 20'h4);
    chk(20'(memData), 20'(ret[15:0]));
    @(posedge ref_clk) #1;
    chk({spWr, vecRd, spWrUser}, {18'h3, !sys && expFlags[FL_STK]});
    chk(spOut, sp - 20'h4);
    chk(vecAddr, isInto ? 20'hFFFE0 : intTableBase + 20'(n) * 20'h4);
    // acknowledge held until the sequencer takes it
    #4 vecAck = 1'b1;
    vecData = nv;
    k = 0;
    do begin
      @(posedge ref_clk) #1 k++;
    end while (done !== 1'b1 && k < 8);
    chk(20'(pcWr), 20'h1);
    chk(pcOut, nv);
    #4 vecAck = 1'b0;
    vecData = ~nv;
    expFlags[FL_IEN] = 1'b0;
    expFlags[FL_DBG] = 1'b0;
    if (isInto || sys) expFlags[FL_STK] = 1'b0;
    chk(20'(flagReg), 20'(expFlags));
  endtask

  // watchdog
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    seed = 32'h7121; start = 1'b0; reqIn = '0; vecAck = 1'b0; vecData = 20'h0;
    intStackPtr = 20'h0; userStackPtr = 20'h0; intTableBase = 20'h0;
    miscompares = 0; compares = 0; expFlags = 8'h00; arst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #5 arst_n = 1'b1;
    chk(20'({busy, flagReg}), 20'h0);
    // random single flag set and clear
    for (i = 0; i < 40; i++) begin
      k = $random(seed) & 7;
      w = $random(seed) & 1;
      issue(mk(w ? OP_FLAG_SET : OP_FLAG_CLR, 1'b0, DK_OTHER, 3'(k), 6'h0, CND_OVF,
               8'h0, 16'h0, 20'h0), 1'b1);
      expFlags[k] = w[0];
      chk(20'(flagReg), 20'(expFlags));
    end
    $display("flag set and clear done");
    // sign extend, byte then word
    for (i = 0; i < 20; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0080 : 16'($random(seed));
      issue(mk(OP_SEXT, 1'b0, DK_ACC_LB, 3'h0, 6'h0, CND_OVF, 8'h0, v, 20'h0), 1'b1);
      e = {{8{v[7]}}, v[7:0]};
      chk({3'h0, resultValid, resultData}, {4'h1, e});
      expFlags[FL_SIGN] = e[15];
      expFlags[FL_ZERO] = (e == 16'h0);
      chk(20'(flagReg), 20'(expFlags));
      issue(mk(OP_SEXT, 1'b1, DK_ACC_LB, 3'h0, 6'h0, CND_OVF, 8'h0, v, 20'h0), 1'b1);
      chk({3'h0, resultHighWr, resultHigh}, {4'h1, {16{v[15]}}});
      chk(20'(flagReg), 20'(expFlags));
    end
    $display("sign extend done");
    // increment over every kind and size
    for (i = 0; i < 32; i++) begin
      k = i & 7;
      w = (i >> 3) & 1;
      v = (i < 16) ? 16'hFFFF : (i < 18) ? 16'h007F : 16'($random(seed));
      issue(mk(OP_INC, w[0], fetbe_kind_t'(k), 3'h0, 6'h0, CND_OVF, 8'h0, v, 20'h0), 1'b0);
      if (w ? (k == 5 || k == 6) : (k < 5)) begin
        e = w ? v + 16'h1 : {v[15:8], v[7:0] + 8'h1};
        chk({2'h0, illegalOp, resultValid, resultData}, {4'h1, e});
        expFlags[FL_SIGN] = w ? e[15] : e[7];
        expFlags[FL_ZERO] = w ? (e == 16'h0) : (e[7:0] == 8'h0);
      end else begin
        chk(20'({illegalOp, resultValid}), 20'h2);
      end
      chk(20'(flagReg), 20'(expFlags));
    end
    $display("increment done");
    // every branch condition under random flags
    for (i = 0; i < 8; i++) begin
      setFlags(8'($random(seed)));
      for (k = 0; k < 14; k++) begin
        d = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($random(seed));
        p = 20'($random(seed));
        issue(mk(OP_JMP_COND, 1'b0, DK_OTHER, 3'h0, 6'h0, fetbe_cond_t'(k), d,
                 16'h0, p), 1'b1);
        chk(20'(pcWr), 20'(condTrue(4'(k), expFlags)));
        if (pcWr === 1'b1)
          chk(pcOut, p + {{12{d[7]}}, d} + ((k < 8) ? 20'h1 : 20'h2));
        chk(20'(flagReg), 20'(expFlags));
      end
    end
    $display("conditional jump done");
    // software traps at the number boundaries and at random
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[FL_IEN] = i[0];
      setFlags(d);
      trap(1'b0, (i < 4) ? ((i == 0) ? 6'd0 : (i == 1) ? 6'd31 : (i == 2) ? 6'd32 : 6'd63)
                         : 6'($random(seed)));
    end
    $display("software trap done");
    // overflow trap not taken, then taken
    setFlags(8'($random(seed)) & 8'hDF);
    issue(mk(OP_OVERFLOW_TRAP_INSTR, 1'b0, DK_OTHER, 3'h0, 6'h0, CND_OVF, 8'h0, 16'h0, 20'h1234), 1'b1);
    chk(20'({pcWr, memWr}), 20'h0);
    for (i = 0; i < 2; i++) begin
      setFlags((8'($random(seed)) | 8'h20) ^ (i[0] ? 8'hC0 : 8'h00));
      trap(1'b1, 6'h0);
    end
    $display("overflow trap done");
    conclude();
  end
endmodule
`default_nettype wire
